//--- shared/lpps_regs.svh
/*
 * constants for the panel power sequencer: timing defaults and widths.
 * assumes inclusion by bare name from logic files; definitions only.
 */
`ifndef LPPS_REGS_SVH
`define LPPS_REGS_SVH

// ----------------------------------------------------------------
// step delay
// ----------------------------------------------------------------
`define LPPS_CLK_MHZ        125
`define LPPS_STEP_US        1
`define LPPS_STEP_CYC       (`LPPS_STEP_US * `LPPS_CLK_MHZ)
`define LPPS_DLY_W          16
`define LPPS_DLY_RST        16'h007d

`endif

//--- shared/lpps_pkg.sv
/*
 * types for the panel power sequencer.
 * assumes lpps_regs.svh is on the include path.
 */
package lpps_pkg;

   typedef enum logic [1:0] {
      LPPS_MODE_CRT,
      LPPS_MODE_PANEL,
      LPPS_MODE_BOTH
   } lpps_mode_type;

   typedef struct packed {
      logic logic_sw;
      logic sig_en;
      logic bias_sw;
      logic light_sw;
   } lpps_rails_type;

endpackage : lpps_pkg

//--- logic/lpps_delay_timer.sv
/*
 * lpps_delay_timer: loadable down counter, pulses done on reaching zero.
 * assumes one clock, synchronous active-low reset, enable freezes it.
 */
`timescale 1ns/1ps
module lpps_delay_timer #(
   parameter int W = 16
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_count,
   output logic              o_done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         run_q;
   logic         run_d;
   logic         done_d;
   logic         done_q;

   always_comb begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (i_load) begin
         cnt_d = (i_count == '0) ? W'(1) : i_count;
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q == W'(1)) begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (i_ce) begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
      end
   end

   assign o_done = done_q;

endmodule : lpps_delay_timer

//--- logic/lpps_sequencer.sv
/*
 * lpps_sequencer: starts and steps the panel power-up and power-down
 * sequences and drives the three supply switch levels.
 * assumes control inputs come from same-clock register logic, and
 * that the external power module acts on the switch levels.
 */
`timescale 1ns/1ps
`include "lpps_regs.svh"
module lpps_sequencer import lpps_pkg::*; #(
   parameter int DLY_W = `LPPS_DLY_W
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_ce,
   input  wire logic              i_panel_power_enable_bit,
   input  wire logic              i_low_power,
   input  wire lpps_mode_type     i_mode,
   input  wire logic [DLY_W-1:0]  i_step_delay,
   output logic                   o_panel_logic_supply_switch,
   output logic                   o_panel_bias_supply_switch,
   output logic                   o_backlight_supply_switch,
   output logic                   o_panel_signal_enable,
   output logic                   o_panel_powered,
   output logic                   o_busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_OFF,
      ST_UP_SIG,
      ST_UP_BIAS,
      ST_UP_LIGHT,
      ST_ON,
      ST_DN_BIAS,
      ST_DN_SIG,
      ST_DN_LOGIC
   } lpps_state_type;

   lpps_state_type state_q;
   lpps_state_type state_d;
   lpps_rails_type rails_q;
   lpps_rails_type rails_d;
   logic           en_q;
   logic           lp_q;
   lpps_mode_type  mode_q;
   logic           active_q;
   logic           active_d;
   logic           up_pend_q;
   logic           up_pend_d;
   logic           dn_pend_q;
   logic           dn_pend_d;
   logic           busy_q;
   logic           busy_d;
   logic           powered_q;
   logic           powered_d;
   logic           load;
   logic           step_done;
   logic           up_trig;
   logic           dn_trig;

   // ----------------------------------------------------------------
   // trigger detection
   // ----------------------------------------------------------------
   always_comb begin
      up_trig = 1'b0;
      dn_trig = 1'b0;
      if (i_panel_power_enable_bit && !en_q) begin
         up_trig = 1'b1;
      end
      if (!i_panel_power_enable_bit && en_q) begin
         dn_trig = 1'b1;
      end
      if (lp_q && !i_low_power && active_q) begin
         up_trig = 1'b1;
      end
      if (!lp_q && i_low_power && active_q) begin
         dn_trig = 1'b1;
      end
      if (mode_q == LPPS_MODE_CRT && i_mode == LPPS_MODE_PANEL) begin
         up_trig = 1'b1;
      end
      if (mode_q == LPPS_MODE_PANEL && i_mode == LPPS_MODE_CRT) begin
         dn_trig = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   lpps_delay_timer #(
      .W (DLY_W)
   ) u_timer (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_load    (load),
      .i_count   (i_step_delay),
      .o_done    (step_done)
   );

   always_comb begin
      state_d   = state_q;
      rails_d   = rails_q;
      load      = 1'b0;
      up_pend_d = up_pend_q;
      dn_pend_d = dn_pend_q;
      // latest trigger wins while a sequence runs; acted on after it ends
      if (up_trig) begin
         up_pend_d = 1'b1;
         dn_pend_d = 1'b0;
      end else if (dn_trig) begin
         dn_pend_d = 1'b1;
         up_pend_d = 1'b0;
      end
      unique case (state_q)
         ST_OFF: begin
            dn_pend_d = 1'b0;
            if (up_pend_d) begin
               up_pend_d        = 1'b0;
               rails_d.logic_sw = 1'b1;
               load             = 1'b1;
               state_d          = ST_UP_SIG;
            end
         end
         ST_UP_SIG: begin
            if (step_done) begin
               rails_d.sig_en = 1'b1;
               load           = 1'b1;
               state_d        = ST_UP_BIAS;
            end
         end
         ST_UP_BIAS: begin
            if (step_done) begin
               rails_d.bias_sw = 1'b1;
               load            = 1'b1;
               state_d         = ST_UP_LIGHT;
            end
         end
         ST_UP_LIGHT: begin
            if (step_done) begin
               rails_d.light_sw = 1'b1;
               state_d          = ST_ON;
            end
         end
         ST_ON: begin
            up_pend_d = 1'b0;
            if (dn_pend_d) begin
               dn_pend_d        = 1'b0;
               rails_d.light_sw = 1'b0;
               load             = 1'b1;
               state_d          = ST_DN_BIAS;
            end
         end
         ST_DN_BIAS: begin
            if (step_done) begin
               rails_d.bias_sw = 1'b0;
               load            = 1'b1;
               state_d         = ST_DN_SIG;
            end
         end
         ST_DN_SIG: begin
            if (step_done) begin
               rails_d.sig_en = 1'b0;
               load           = 1'b1;
               state_d        = ST_DN_LOGIC;
            end
         end
         ST_DN_LOGIC: begin
            if (step_done) begin
               rails_d.logic_sw = 1'b0;
               state_d          = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
            rails_d = '0;
         end
      endcase
      // active remembers panel state across low-power entry; next state
      // so a panel switched off on the last edge no longer counts as active
      active_d  = active_q;
      if (!i_low_power && !lp_q) begin
         active_d = (state_d != ST_OFF);
      end
      busy_d    = (state_d != ST_OFF) && (state_d != ST_ON);
      powered_d = (state_d == ST_ON);
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_q   <= ST_OFF;
         rails_q   <= '0;
         en_q      <= 1'b0;
         lp_q      <= 1'b0;
         mode_q    <= LPPS_MODE_CRT;
         active_q  <= 1'b0;
         up_pend_q <= 1'b0;
         dn_pend_q <= 1'b0;
         busy_q    <= 1'b0;
         powered_q <= 1'b0;
      end else if (i_ce) begin
         state_q   <= state_d;
         rails_q   <= rails_d;
         en_q      <= i_panel_power_enable_bit;
         lp_q      <= i_low_power;
         mode_q    <= i_mode;
         active_q  <= active_d;
         up_pend_q <= up_pend_d;
         dn_pend_q <= dn_pend_d;
         busy_q    <= busy_d;
         powered_q <= powered_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_panel_logic_supply_switch = rails_q.logic_sw;
   assign o_panel_bias_supply_switch  = rails_q.bias_sw;
   assign o_backlight_supply_switch   = rails_q.light_sw;
   assign o_panel_signal_enable       = rails_q.sig_en;
   assign o_panel_powered             = powered_q;
   assign o_busy                      = busy_q;

endmodule : lpps_sequencer

//--- tb/lpps_sequencer_monitor.sv
/* lpps_sequencer_monitor: checks on the panel power sequencer outputs.
   assumes bind onto lpps_sequencer, one clock, synchronous reset. */
`timescale 1ns/1ps
module lpps_sequencer_monitor import lpps_pkg::*; #(
   parameter int DLY_W = 16
) (
   input wire logic             i_sys_clk,
   input wire logic             i_rst_n,
   input wire logic             i_ce,
   input wire logic             i_panel_power_enable_bit,
   input wire logic             i_low_power,
   input wire lpps_mode_type    i_mode,
   input wire logic [DLY_W-1:0] i_step_delay,
   input wire logic             o_panel_logic_supply_switch,
   input wire logic             o_panel_bias_supply_switch,
   input wire logic             o_backlight_supply_switch,
   input wire logic             o_panel_signal_enable,
   input wire logic             o_panel_powered,
   input wire logic             o_busy
);
   logic ce_q;
   wire  ok = i_ce & ce_q;
   wire  en = i_panel_power_enable_bit;
   wire  lp = i_low_power;
   wire  lg = o_panel_logic_supply_switch;
   wire  bs = o_panel_bias_supply_switch;
   wire  lt = o_backlight_supply_switch;
   wire  sg = o_panel_signal_enable;
   // edge history only counts across two running edges
   always_ff @(posedge i_sys_clk) ce_q <= i_ce;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence idle_off; !o_busy && !o_panel_powered; endsequence
   sequence idle_on; !o_busy && o_panel_powered; endsequence
   // ----------------------------------------------------------------
   // triggers and step order
   // ----------------------------------------------------------------
   up_start_a: assert property ((ok && $rose(en) && !lp) ##0 idle_off
      |=> lg && o_busy && !sg) else $error("power-up did not start");
   down_start_a: assert property ((ok && $fell(en) && !lp) ##0 idle_on
      |=> !lt && bs && o_busy && !o_panel_powered) else $error("power-down did not start");
   mode_up_a: assert property ((ok && $past(i_mode) == LPPS_MODE_CRT
      && i_mode == LPPS_MODE_PANEL && !lp) ##0 idle_off |=> lg && o_busy) else $error("mode up");
   mode_down_a: assert property ((ok && $past(i_mode) == LPPS_MODE_PANEL
      && i_mode == LPPS_MODE_CRT) ##0 idle_on |=> !lt && o_busy) else $error("mode down");
   sleep_down_a: assert property ((ok && $rose(lp)) ##0 idle_on
      |=> !lt && o_busy) else $error("standby entry did not power down");
   sig_order_a: assert property ($rose(sg) |-> lg && !bs && $past(lg, 2))
      else $error("signals before logic supply");
   bias_order_a: assert property ($rose(bs) |-> sg && !lt && $past(sg, 2))
      else $error("bias before signals");
   light_order_a: assert property ($rose(lt) |-> bs && o_panel_powered && !o_busy
      && $past(bs, 2)) else $error("backlight before bias");
   down_order_a: assert property ($fell(lg) |-> !sg && !bs && !o_busy
      && $past(sg, 2) == 1'b0) else $error("logic supply off too early");
   ignore_up_a: assert property ((ok && $rose(en) && !lp) ##0 idle_on
      |=> idle_on) else $error("redundant power-up acted");
endmodule : lpps_sequencer_monitor

bind lpps_sequencer lpps_sequencer_monitor #(.DLY_W(DLY_W)) lpps_sequencer_monitor_inst (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
   .i_panel_power_enable_bit(i_panel_power_enable_bit), .i_low_power(i_low_power),
   .i_mode(i_mode), .i_step_delay(i_step_delay),
   .o_panel_logic_supply_switch(o_panel_logic_supply_switch),
   .o_panel_bias_supply_switch(o_panel_bias_supply_switch),
   .o_backlight_supply_switch(o_backlight_supply_switch),
   .o_panel_signal_enable(o_panel_signal_enable),
   .o_panel_powered(o_panel_powered), .o_busy(o_busy));

//--- tb/lpps_power_module.sv
/* lpps_power_module: model of the external module switching panel supplies.
   assumes switch levels arrive as plain wires; no supply ramp is modelled. */
`timescale 1ns/1ps
module lpps_power_module import lpps_pkg::*; (
   input  wire logic     i_logic_sw,
   input  wire logic     i_sig_en,
   input  wire logic     i_bias_sw,
   input  wire logic     i_light_sw,
   output lpps_rails_type o_rails,
   output logic          o_fault
);
   // one driver for the whole rail word, fields in struct order
   assign o_rails = {i_logic_sw, i_sig_en, i_bias_sw, i_light_sw};
   // anything live on a dead logic rail would harm the panel
   assign o_fault = (i_bias_sw | i_light_sw | i_sig_en) & ~i_logic_sw;
endmodule : lpps_power_module

//--- tb/lpps_sequencer_tb.sv
/* lpps_sequencer_tb: drives every trigger and checks each switch step.
   assumes the power module model and the bound monitor are compiled. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module lpps_sequencer_tb import lpps_pkg::*;;
   logic           sys_clk, rst_n, ce, en, lp;
   lpps_mode_type  mode;
   logic [15:0]    dly;
   logic           lg, bs, lt, sg, pwr, busy, fault;
   lpps_rails_type rails;
   int             fails = 0;
   int             compares = 0;
   lpps_sequencer lpps_sequencer_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_panel_power_enable_bit(en), .i_low_power(lp), .i_mode(mode), .i_step_delay(dly),
      .o_panel_logic_supply_switch(lg), .o_panel_bias_supply_switch(bs),
      .o_backlight_supply_switch(lt), .o_panel_signal_enable(sg),
      .o_panel_powered(pwr), .o_busy(busy));
   lpps_power_module lpps_power_module_inst (.i_logic_sw(lg), .i_sig_en(sg),
      .i_bias_sw(bs), .i_light_sw(lt), .o_rails(rails), .o_fault(fault));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic walk(input bit up, input int d);
      logic [3:0] r;
      r = up ? 4'h8 : 4'he;
      @(posedge sys_clk) #1;
      `CHK("first", r, {lg, sg, bs, lt})
      for (int k = 1; k < 4; k++) begin
         repeat (d) @(posedge sys_clk);
         #1 `CHK("hold", r, {lg, sg, bs, lt})
         @(posedge sys_clk) #1;
         r = up ? {1'b1, r[3:1]} : {r[2:0], 1'b0};
         `CHK("step", r, {lg, sg, bs, lt})
         `CHK("module", r, rails)
      end
      `CHK("powered", up, pwr)
      `CHK("busy", 1'b0, busy)
      `CHK("fault", 1'b0, fault)
   endtask : walk
   task automatic quiet();
      repeat (4) @(posedge sys_clk) #1;
      `CHK("idle", 1'b0, busy)
   endtask : quiet
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      fails++;
      final_report();
   end
   initial begin
      rst_n = 1'b0; ce = 1'b1; en = 1'b0; lp = 1'b0; mode = LPPS_MODE_CRT; dly = 16'h0001;
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      `CHK("reset", 6'h00, {lg, sg, bs, lt, pwr, busy})
      en = 1'b1; walk(1'b1, 1);
      mode = LPPS_MODE_PANEL; quiet();
      dly = 16'h0000; mode = LPPS_MODE_CRT; walk(1'b0, 1);
      dly = 16'h0002; mode = LPPS_MODE_PANEL; walk(1'b1, 2);
      $display("test mode and enable done");
      lp = 1'b1; walk(1'b0, 2);
      lp = 1'b0; walk(1'b1, 2);
      en = 1'b0; walk(1'b0, 2);
      lp = 1'b1; quiet();
      lp = 1'b0; quiet();
      $display("test low power done");
      // down request mid power-up waits for the up walk, then runs
      en = 1'b1; repeat (3) @(posedge sys_clk) #1;
      en = 1'b0; `CHK("running", 1'b1, busy)
      repeat (30) @(posedge sys_clk) #1;
      `CHK("final", 6'h00, {lg, sg, bs, lt, pwr, busy})
      $display("test mid sequence done");
      // only crt-only and panel-only moves count; both-mode moves are silent
      mode = LPPS_MODE_BOTH; quiet();
      mode = LPPS_MODE_PANEL; quiet();
      mode = LPPS_MODE_CRT; quiet();
      // frozen enable must hold the edge history as well as the outputs
      ce = 1'b0; mode = LPPS_MODE_PANEL; repeat (4) @(posedge sys_clk) #1;
      `CHK("frozen", 6'h00, {lg, sg, bs, lt, pwr, busy})
      ce = 1'b1; walk(1'b1, 2);
      en = 1'b1; quiet();
      `CHK("still on", 1'b1, pwr)
      en = 1'b0; walk(1'b0, 2);
      $display("test mode both and enable done");
      final_report();
   end
endmodule : lpps_sequencer_tb
